// File: shared/flash_crc_pkg.sv
// Shared constants and types for the CRC and mode command engine.
// Assumes both clock domains import it whole.
package flash_crc_pkg;
  // Command codes
  localparam logic [7:0] CMD_ADDR4_ENTER = 8'hB7;
  localparam logic [7:0] CMD_ADDR4_EXIT = 8'hE9;
  localparam logic [7:0] CMD_QUAD_ENTER = 8'h35;
  localparam logic [7:0] CMD_QUAD_EXIT = 8'hF5;
  localparam logic [7:0] CMD_CRC = 8'h9B;
  localparam logic [7:0] CMD_CRC_SUB = 8'h27;
  localparam logic [7:0] CMD_CRC_RANGE = 8'hFE;
  localparam logic [7:0] CMD_READBACK = 8'h96;
  // Zero-based byte positions in a frame
  localparam logic [6:0] POS_SUB = 7'h01;
  localparam logic [6:0] POS_OPT = 7'h02;
  localparam logic [6:0] POS_EXP = 7'h03;
  localparam logic [6:0] POS_START = 7'h0B;
  localparam logic [6:0] POS_END = 7'h0F;
  localparam logic [6:0] POS_LAST = 7'h12;
  localparam logic [6:0] POS_MAX = 7'h7F;
  localparam logic [6:0] RB_BYTES = 7'h08;
  // Flag status bit positions
  localparam int FSR_RANGE = 1;
  localparam int FSR_SUSP = 2;
  localparam int FSR_PROG = 4;
  // CRC generator and reset values
  localparam logic [63:0] CRC_POLY = 64'h42F0_E1EB_A9EA_3693;
  localparam logic [63:0] CRC_INIT = 64'h0;
  localparam logic [63:0] RB_RESET = 64'h0;
  localparam int SECTOR_W = 16;
  typedef enum logic [2:0] {OP_READ_MEM, OP_READ_STATUS, OP_PROGRAM,
    OP_ERASE, OP_WRITE_NV, OP_WRITE_VOL, OP_SUSPEND} op_class_e;
  typedef enum logic [1:0] {ST_STANDBY, ST_PE_RUN, ST_SUSP_OTHER,
    ST_ERASE_SUSP} dev_state_e;
  typedef enum logic [1:0] {CRC_IDLE, CRC_FETCH, CRC_COMPARE} crc_state_e;
endpackage

// File: core/crc64_step.sv
// One-byte step of the 64-bit CRC, bits taken LSB first.
// Assumes the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module crc64_step import flash_crc_pkg::*; (
  // Running remainder and data
  input wire logic [63:0] crc_in,
  input wire logic [7:0] data,
  // Updated remainder
  output logic [63:0] crc_out
);
  // Shift the byte in, LSB first
  always_comb begin
    crc_out = crc_in;
    for (int i = 0; i < 8; i++) begin
      if (crc_out[63] ^ data[i]) begin
        crc_out = {crc_out[62:0], 1'b0} ^ CRC_POLY; // [RULE4] [RULE5]
      end else begin
        crc_out = {crc_out[62:0], 1'b0};
      end
    end
  end
endmodule // crc64_step
`default_nettype wire

// File: core/serial_link_front.sv
// Serial front end on the link clock: framing, modes, readback.
// Assumes the core clock domain syncs the toggle and modes, and reads the fields after the toggle.
`timescale 1ns/1ps
`default_nettype none
module serial_link_front import flash_crc_pkg::*; (
  // Link clock and select
  input wire logic sclk,
  input wire logic cs_n,
  // Serial data lines
  input wire logic [3:0] serial_data_lines_in,
  output logic [3:0] serial_data_lines_out,
  output logic [3:0] serial_data_lines_oe,
  // From core domain
  input wire logic sys_rst,
  input wire logic [63:0] rb_word,
  input wire logic rb_toggle,
  // To core domain
  output logic seq_toggle,
  output logic [63:0] seq_exp,
  output logic [31:0] seq_start,
  output logic [31:0] seq_end,
  output logic addr4,
  output logic quad
);
  typedef struct packed {
    logic [2:0] bits; logic [6:0] idx; logic [7:0] sh;
    logic [7:0] opc; logic hdr; logic [3:0] dout; logic [3:0] doe;
  } frame_s;
  typedef struct packed {
    logic r1, r2, t1, t2, tseen; logic [63:0] rb;
    logic addr4, quad, seq; logic [63:0] exp; logic [31:0] sa, ea;
  } keep_s;
  frame_s fr, next_fr;
  keep_s kp, next_kp;
  logic [3:0] sum;
  logic done;
  logic [7:0] shin, ob;

  // Readback byte at a location, zero past the stored word
  function automatic logic [7:0] rb_byte(input logic [63:0] w, input logic [6:0] loc);
    return (loc < RB_BYTES) ? w[{loc[2:0], 3'b000} +: 8] : 8'h00; // [RULE16]
  endfunction

  // Next state of frame and persistent logic
  always_comb begin
    next_fr = fr;
    next_kp = kp;
    sum = {1'b0, fr.bits} + (kp.quad ? 4'h4 : 4'h1);
    done = sum[3];
    shin = kp.quad ? {fr.sh[3:0], serial_data_lines_in} : {fr.sh[6:0], serial_data_lines_in[0]};
    next_fr.bits = sum[2:0];
    next_fr.sh = shin;
    if (done) begin
      if (fr.idx != POS_MAX) next_fr.idx = fr.idx + 7'h01;
      if (fr.idx == 7'h00) next_fr.opc = shin;
      if (fr.idx == 7'h00) next_fr.hdr = (shin == CMD_CRC); // [RULE17]
      if (fr.idx == POS_SUB) next_fr.hdr = fr.hdr && (shin == CMD_CRC_SUB);
      if (fr.idx == POS_OPT) next_fr.hdr = fr.hdr && (shin == CMD_CRC_RANGE);
    end
    ob = rb_byte(kp.rb, next_fr.idx - 7'h01);
    next_fr.dout = 4'h0;
    next_fr.doe = 4'h0;
    if (next_fr.opc == CMD_READBACK && next_fr.idx != 7'h00) begin
      next_fr.doe = kp.quad ? 4'hF : 4'h2;
      if (kp.quad) next_fr.dout = next_fr.bits[2] ? ob[3:0] : ob[7:4];
      else next_fr.dout = {2'b00, ob[3'h7 - next_fr.bits], 1'b0};
    end
    // Mode commands act as their last bit lands
    if (done && fr.idx == 7'h00) begin
      if (shin == CMD_ADDR4_ENTER) next_kp.addr4 = 1'b1; // [RULE1]
      if (shin == CMD_ADDR4_EXIT) next_kp.addr4 = 1'b0; // [RULE1]
      if (shin == CMD_QUAD_ENTER) next_kp.quad = 1'b1; // [RULE2] [RULE3]
      if (shin == CMD_QUAD_EXIT) next_kp.quad = 1'b0; // [RULE2]
    end
    // CRC sequence fields, LSB byte first
    if (done && fr.hdr && fr.idx >= POS_EXP) begin
      if (fr.idx < POS_START) next_kp.exp = {shin, kp.exp[63:8]}; // [RULE18]
      else if (fr.idx < POS_END) next_kp.sa = {shin, kp.sa[31:8]};
      else if (fr.idx <= POS_LAST) next_kp.ea = {shin, kp.ea[31:8]};
      if (fr.idx == POS_LAST) next_kp.seq = ~kp.seq;
    end
    // Readback word taken on its toggle
    next_kp.t1 = rb_toggle;
    next_kp.t2 = kp.t1;
    if (kp.t2 != kp.tseen) begin
      next_kp.tseen = kp.t2;
      next_kp.rb = rb_word;
    end
    next_kp.r1 = sys_rst;
    next_kp.r2 = kp.r1;
    if (kp.r2) begin
      next_kp = '0; // [RULE15]
      next_kp.r1 = sys_rst;
      next_kp.r2 = kp.r1;
    end
  end

  // Frame state ends with the frame itself
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) fr <= '0;
    else fr <= next_fr;
  end

  // Persistent link state
  always_ff @(posedge sclk) begin
    kp <= next_kp;
  end

  assign serial_data_lines_out = fr.dout;
  assign serial_data_lines_oe = fr.doe;
  assign seq_toggle = kp.seq;
  assign seq_exp = kp.exp;
  assign seq_start = kp.sa;
  assign seq_end = kp.ea;
  assign addr4 = kp.addr4;
  assign quad = kp.quad;
endmodule // serial_link_front
`default_nettype wire

// File: core/flash_crc_mode_cmd_engine.sv
// Command engine: range CRC check, readback, state gating.
// Assumes array reads answer on the core clock; link on sclk.
//
// Operation
// [RULE1] B7h enters, E9h leaves 4-byte addressing
// [RULE2] 35h enters, F5h leaves quad protocol
// [RULE3] Host sends quad commands without write enable
// [RULE4] CRC-64 over range, compared with expected
// [RULE5] Bytes fed LSB first, zero start value
// [RULE6] Write enable latch ignored for CRC
// [RULE7] End below start aborts, sets bit 1
// [RULE8] Range is byte exact, both ends included
// [RULE9] Host keeps range within one die
// [RULE10] Mismatch sets flag bit 4
// [RULE11] Suspend sets bit 2, cleared at finish
// [RULE12] Hardware or software reset aborts check
// [RULE13] Failing CRC stored in readback register
// [RULE14] Readback cleared when each check starts
// [RULE15] Readback cleared on any reset
// [RULE16] Readback read LSB first, zeros beyond
// [RULE17] Host sends 9Bh, 27h, FEh first
// [RULE18] Then expected CRC, start, end addresses
// [RULE19] Check starts as select rises
// [RULE20] One state; standby refuses only suspend
// [RULE21] Busy accepts status reads and suspend
// [RULE22] Suspend refuses erase, nonvolatile writes, suspend
// [RULE23] Erase suspend refuses program in its sector
// [RULE24] Reads accepted in every suspend state
// [RULE25] Flag bit 4 is the program error
// [RULE26] Refused operations change nothing; here a refused program into the suspended sector sets flag bit 4
`timescale 1ns/1ps
`default_nettype none
module flash_crc_mode_cmd_engine import flash_crc_pkg::*; (
  // Core clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] serial_data_lines_in,
  output logic [3:0] serial_data_lines_out,
  output logic [3:0] serial_data_lines_oe,
  // Software reset
  input wire logic soft_reset,
  // Array read port
  output logic mem_rd_req,
  output logic [31:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  input wire logic mem_rd_valid,
  // Device state
  input wire logic pe_busy,
  input wire logic erase_suspended,
  input wire logic other_suspended,
  input wire logic [SECTOR_W-1:0] suspended_sector,
  // Operation gate
  input wire logic op_valid,
  input wire op_class_e op_class,
  input wire logic [SECTOR_W-1:0] op_sector,
  output logic op_accept,
  output logic op_refuse,
  input wire logic flag_clear,
  // Status
  output logic [7:0] flag_status,
  output logic crc_busy,
  output logic addr4_mode,
  output logic quad_mode
);
  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic cs1, cs2, csp;
    logic sq1, sq2, sqseen, pend;
    logic [1:0] md1, md2;
    crc_state_e fsm;
    logic [63:0] exp, crc, rb;
    logic [31:0] addr, stop;
    logic rbt;
    logic f_range, f_susp, f_prog;
  } core_s;
  core_s st, next_st;

  logic seq_toggle;
  logic [63:0] seq_exp;
  logic [31:0] seq_start;
  logic [31:0] seq_end;
  logic link_addr4;
  logic link_quad;
  logic [63:0] crc_next;
  logic cs_rise;
  logic seq_new;
  logic start;
  logic allowed;
  dev_state_e dstate;

  ////////////////////////////////////////////////////////////////////////
  // Link side and CRC step
  serial_link_front u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .serial_data_lines_in(serial_data_lines_in),
    .serial_data_lines_out(serial_data_lines_out),
    .serial_data_lines_oe(serial_data_lines_oe),
    .sys_rst(sys_rst),
    .rb_word(st.rb),
    .rb_toggle(st.rbt),
    .seq_toggle(seq_toggle),
    .seq_exp(seq_exp),
    .seq_start(seq_start),
    .seq_end(seq_end),
    .addr4(link_addr4),
    .quad(link_quad)
  );

  crc64_step u_crc (
    .crc_in(st.crc),
    .data(mem_rd_data),
    .crc_out(crc_next)
  );

  ////////////////////////////////////////////////////////////////////////
  // Acceptance per device state
  function automatic logic op_ok(input dev_state_e s, input op_class_e c,
                                 input logic same_sector);
    logic ok;
    ok = 1'b0;
    case (c)
      OP_READ_MEM: ok = (s != ST_PE_RUN); // [RULE24]
      OP_READ_STATUS: ok = 1'b1; // [RULE21]
      OP_PROGRAM: ok = (s == ST_STANDBY) ||
                       (s == ST_ERASE_SUSP && !same_sector); // [RULE23]
      OP_ERASE: ok = (s == ST_STANDBY); // [RULE22]
      OP_WRITE_NV: ok = (s == ST_STANDBY); // [RULE22]
      OP_WRITE_VOL: ok = (s != ST_PE_RUN); // [RULE22]
      OP_SUSPEND: ok = (s == ST_PE_RUN); // [RULE20]
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // One state only, by priority
  always_comb begin
    if (pe_busy) dstate = ST_PE_RUN; // [RULE20]
    else if (erase_suspended) dstate = ST_ERASE_SUSP;
    else if (other_suspended) dstate = ST_SUSP_OTHER;
    else dstate = ST_STANDBY;
  end

  // Gate answer; suspend taken while a check runs
  always_comb begin
    allowed = op_ok(dstate, op_class, op_sector == suspended_sector);
    if (op_class == OP_SUSPEND && st.fsm != CRC_IDLE) allowed = 1'b1; // [RULE11]
    op_accept = op_valid && allowed;
    op_refuse = op_valid && !allowed; // [RULE26]
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    // Select and sequence crossings
    next_st.cs1 = cs_n;
    next_st.cs2 = st.cs1;
    next_st.csp = st.cs2;
    cs_rise = st.cs2 && !st.csp;
    next_st.sq1 = seq_toggle;
    next_st.sq2 = st.sq1;
    seq_new = (st.sq2 != st.sqseen);
    if (seq_new) begin
      next_st.sqseen = st.sq2;
      next_st.pend = 1'b1;
    end
    if (cs_rise) next_st.pend = 1'b0;
    next_st.md1 = {link_quad, link_addr4};
    next_st.md2 = st.md1;
    start = cs_rise && (st.pend || seq_new) && st.fsm == CRC_IDLE; // [RULE19] [RULE6]
    // Flag clears first so sets win
    if (flag_clear) begin
      next_st.f_range = 1'b0;
      next_st.f_prog = 1'b0;
    end
    if (op_valid && op_class == OP_SUSPEND && st.fsm != CRC_IDLE) begin
      next_st.f_susp = 1'b1; // [RULE11]
    end
    if (op_valid && op_class == OP_PROGRAM && dstate == ST_ERASE_SUSP &&
        op_sector == suspended_sector) begin
      next_st.f_prog = 1'b1; // [RULE25]
    end
    // Check sequencer
    case (st.fsm)
      CRC_IDLE: begin
        if (start) begin
          // Link copy follows at the end, one toggle per check
          next_st.rb = RB_RESET; // [RULE14]
          if (seq_end < seq_start) begin
            next_st.f_range = 1'b1; // [RULE7]
            next_st.rbt = ~st.rbt;
          end else begin
            next_st.crc = CRC_INIT; // [RULE5]
            next_st.exp = seq_exp;
            next_st.addr = seq_start;
            next_st.stop = seq_end;
            next_st.fsm = CRC_FETCH;
          end
        end
      end
      CRC_FETCH: begin
        if (mem_rd_valid) begin
          next_st.crc = crc_next; // [RULE4]
          if (st.addr == st.stop) next_st.fsm = CRC_COMPARE; // [RULE8]
          else next_st.addr = st.addr + 32'h1;
        end
      end
      CRC_COMPARE: begin
        if (st.crc != st.exp) begin
          next_st.f_prog = 1'b1; // [RULE10]
          next_st.rb = st.crc; // [RULE13]
        end
        next_st.rbt = ~st.rbt; // [RULE14]
        next_st.f_susp = 1'b0; // [RULE11]
        next_st.fsm = CRC_IDLE;
      end
      default: next_st.fsm = CRC_IDLE;
    endcase
    // Software reset aborts and clears readback
    if (soft_reset) begin
      next_st.fsm = CRC_IDLE; // [RULE12]
      next_st.f_susp = 1'b0;
      next_st.rb = RB_RESET; // [RULE15]
      next_st.rbt = ~st.rbt;
    end
  end

  // Register all core state; select syncs rest high, so no false rise
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= '0; // [RULE12] [RULE15]
      st.cs1 <= 1'b1;
      st.cs2 <= 1'b1;
      st.csp <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign mem_rd_req = (st.fsm == CRC_FETCH);
  assign mem_rd_addr = st.addr;
  assign crc_busy = (st.fsm != CRC_IDLE);
  assign addr4_mode = st.md2[0];
  assign quad_mode = st.md2[1];
  always_comb begin
    flag_status = 8'h00;
    flag_status[FSR_RANGE] = st.f_range;
    flag_status[FSR_SUSP] = st.f_susp;
    flag_status[FSR_PROG] = st.f_prog;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_range_abort: assert property ( // [RULE7]
    start && seq_end < seq_start && !soft_reset
    |=> st.fsm == CRC_IDLE && flag_status[FSR_RANGE] && st.rb == RB_RESET)
    else $error("range error not flagged");

  a_start_init: assert property ( // [RULE5]
    start && seq_end >= seq_start && !soft_reset
    |=> crc_busy && st.crc == CRC_INIT && mem_rd_addr == $past(seq_start))
    else $error("check not started from zero");

  a_rb_cleared: assert property ( // [RULE14]
    start && !soft_reset |=> st.rb == RB_RESET)
    else $error("readback not cleared at start");

  a_mismatch_flag: assert property ( // [RULE10]
    st.fsm == CRC_COMPARE && st.crc != st.exp && !soft_reset
    |=> flag_status[FSR_PROG] && st.rb == $past(st.crc) && st.rbt != $past(st.rbt))
    else $error("mismatch not reported");

  a_pass_zero: assert property ( // [RULE13]
    st.fsm == CRC_COMPARE && st.crc == st.exp
    |=> st.rb == $past(st.rb) && st.rbt != $past(st.rbt))
    else $error("passing check changed readback");

  a_susp_taken: assert property ( // [RULE11]
    op_valid && op_class == OP_SUSPEND && st.fsm == CRC_FETCH && !soft_reset
    |-> op_accept ##1 flag_status[FSR_SUSP] && crc_busy)
    else $error("suspend during check mishandled");

  a_susp_release: assert property ( // [RULE11]
    st.fsm == CRC_COMPARE |=> !flag_status[FSR_SUSP] && !crc_busy)
    else $error("suspend flag left after check");

  a_soft_abort: assert property ( // [RULE12]
    soft_reset |=> !crc_busy && !mem_rd_req && st.rb == RB_RESET)
    else $error("software reset did not abort");

  a_addr_steps: assert property ( // [RULE8]
    mem_rd_req && mem_rd_valid && mem_rd_addr != st.stop && !soft_reset
    |=> mem_rd_addr == $past(mem_rd_addr) + 32'h1 && mem_rd_req)
    else $error("address did not step by one byte");

  a_busy_refuse: assert property ( // [RULE21]
    op_valid && pe_busy && op_class != OP_READ_STATUS &&
    op_class != OP_SUSPEND |-> op_refuse && !op_accept)
    else $error("busy state accepted an operation");

  a_standby_susp: assert property ( // [RULE20]
    op_valid && dstate == ST_STANDBY && !crc_busy &&
    op_class == OP_SUSPEND |-> op_refuse)
    else $error("suspend accepted in standby");

  a_sector_prog: assert property ( // [RULE23]
    op_valid && dstate == ST_ERASE_SUSP && op_class == OP_PROGRAM &&
    op_sector == suspended_sector |-> op_refuse ##1 flag_status[FSR_PROG])
    else $error("program into suspended sector");

  a_flag_set_wins: assert property ( // [RULE25]
    flag_clear && st.fsm == CRC_COMPARE && st.crc != st.exp && !soft_reset
    |=> flag_status[FSR_PROG])
    else $error("clear beat a same-cycle set");

  c_check_pass: cover property (st.fsm == CRC_COMPARE && st.crc == st.exp);
  c_check_fail: cover property (st.fsm == CRC_COMPARE && st.crc != st.exp);
  c_range_err: cover property (start && seq_end < seq_start);
  c_susp_in_crc: cover property (op_valid && op_class == OP_SUSPEND && crc_busy);
endmodule // flash_crc_mode_cmd_engine
`default_nettype wire

// File: sim/host_spi_model.sv
// Host serial controller model: frames, bytes and readback bits.
// Assumes the device samples and drives on rising sclk.
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
  // Link outputs
  output logic sclk,
  output logic cs_n,
  output logic [3:0] dq_out,
  // Data from device
  input wire logic [3:0] dq_in
);
  logic q;
  ////////////////////////////////////////////////////////////////////
  // Idle levels at time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dq_out = 4'h5;
    q = 1'b0;
  end
  // One 32 ns link cycle
  task automatic tick();
    #16 sclk = 1'b1;
    #16 sclk = 1'b0;
  endtask
  // Select high; link reset needs a running clock here
  task automatic idle(input int n);
    repeat (n) begin
      dq_out = ~dq_out;
      tick();
    end
  endtask
  // Open a frame
  task automatic open();
    cs_n = 1'b0;
  endtask
  // Select rise confirms the frame; released lines keep changing
  task automatic close();
    dq_out = ~dq_out;
    #16 cs_n = 1'b1;
    #500;
  endtask
  // One byte MSB first, on line 0 or on all four lines
  task automatic put(input logic [7:0] b);
    if (q) begin
      dq_out = b[7:4];
      tick();
      dq_out = b[3:0];
      tick();
    end else begin
      for (int i = 7; i >= 0; i--) begin
        dq_out = {~dq_out[3:1], b[i]};
        tick();
      end
    end
  endtask
  // Sample line 1 just before each rising edge
  task automatic get(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      dq_out = ~dq_out;
      #16 b[i] = dq_in[1];
      sclk = 1'b1;
      #16 sclk = 1'b0;
    end
  endtask
endmodule // host_spi_model
`default_nettype wire

// File: sim/flash_crc_mode_cmd_engine_tb_top.sv
// Testbench: modes, range checks, readback and operation gate.
// Assumes an array model here and the host model on the link.
`timescale 1ns/1ps
`default_nettype none
module flash_crc_mode_cmd_engine_tb_top import flash_crc_pkg::*; ;
  logic clock;
  logic sys_rst;
  logic soft_reset;
  logic sclk;
  logic cs_n;
  logic [3:0] din;
  logic [3:0] dout;
  logic [3:0] oe;
  logic mem_rd_req;
  logic [31:0] mem_rd_addr;
  logic [7:0] mem_rd_data;
  logic mem_rd_valid;
  logic pe_busy;
  logic erase_suspended;
  logic other_suspended;
  logic [SECTOR_W-1:0] suspended_sector;
  logic op_valid;
  op_class_e op_class;
  logic [SECTOR_W-1:0] op_sector;
  logic op_accept;
  logic op_refuse;
  logic flag_clear;
  logic [7:0] flag_status;
  logic crc_busy;
  logic addr4_mode;
  logic quad_mode;
  int n_mismatch;
  int n_compared;
  int n_rd;
  int lat;
  int wcnt;
  logic [31:0] nxt;
  logic [63:0] c;
  logic [79:0] v;

  host_spi_model h (.sclk(sclk), .cs_n(cs_n), .dq_out(din), .dq_in(dout));
  flash_crc_mode_cmd_engine dut (.clock(clock), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
    .serial_data_lines_in(din), .serial_data_lines_out(dout), .serial_data_lines_oe(oe),
    .soft_reset(soft_reset), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .mem_rd_valid(mem_rd_valid), .pe_busy(pe_busy),
    .erase_suspended(erase_suspended), .other_suspended(other_suspended),
    .suspended_sector(suspended_sector), .op_valid(op_valid), .op_class(op_class),
    .op_sector(op_sector), .op_accept(op_accept), .op_refuse(op_refuse),
    .flag_clear(flag_clear), .flag_status(flag_status), .crc_busy(crc_busy),
    .addr4_mode(addr4_mode), .quad_mode(quad_mode));

  ////////////////////////////////////////////////////////////////////
  // Core clock, 100 ns
  always #50 clock = ~clock;
  // Array contents
  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  // Bitwise CRC, data LSB first, zero start
  function automatic logic [63:0] ref_crc(input int unsigned s, input int unsigned e);
    logic [63:0] r;
    logic [7:0] d;
    logic fb;
    r = 64'h0;
    for (int unsigned a = s; a <= e; a++) begin
      d = mem_byte(a);
      for (int i = 0; i < 8; i++) begin
        fb = r[63] ^ d[i];
        r = {r[62:0], 1'b0} ^ (fb ? CRC_POLY : 64'h0);
      end
    end
    return r;
  endfunction
  // Acceptance per state and class
  function automatic logic ok_in(input int st, input op_class_e k);
    case (st)
      0: return k != OP_SUSPEND;
      1: return k inside {OP_READ_STATUS, OP_SUSPEND};
      default: return k inside {OP_READ_MEM, OP_READ_STATUS, OP_WRITE_VOL} ||
        (st == 3 && k == OP_PROGRAM);
    endcase
  endfunction
  // Array model: answers after lat cycles, checks address order
  always @(negedge clock) begin
    mem_rd_valid <= 1'b0;
    if (mem_rd_req && !mem_rd_valid) begin
      if (wcnt >= lat) begin
        check(80'(mem_rd_addr), 80'(nxt));
        mem_rd_valid <= 1'b1;
        mem_rd_data <= mem_byte(mem_rd_addr);
        nxt <= nxt + 32'h1;
        n_rd <= n_rd + 1;
        wcnt <= 0;
      end else begin
        wcnt <= wcnt + 1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // One-byte command frame
  task automatic cmd(input logic [7:0] b);
    h.open();
    h.put(b);
    h.close();
  endtask
  // Range check frame, fields LSB byte first
  task automatic run_crc(input logic [63:0] exp, input logic [31:0] s, input logic [31:0] e);
    logic [127:0] p;
    p = {e, s, exp};
    nxt = s;
    n_rd = 0;
    h.open();
    h.put(CMD_CRC);
    h.put(CMD_CRC_SUB);
    h.put(CMD_CRC_RANGE);
    for (int i = 0; i < 16; i++) h.put(p[8*i+:8]);
    h.close();
    cyc(1);
    for (int k = 0; k < 20 && crc_busy !== 1'b1; k++) cyc(1);
  endtask
  task automatic wait_done();
    for (int k = 0; k < 3000 && crc_busy !== 1'b0; k++) cyc(1);
  endtask
  // Ten readback locations
  task automatic read_rb(output logic [79:0] r);
    logic [7:0] b;
    h.idle(8);
    h.open();
    h.put(CMD_READBACK);
    check(80'(oe), 80'h2);
    for (int i = 0; i < 10; i++) begin
      h.get(b);
      r[8*i+:8] = b;
    end
    h.close();
    check(80'(oe), 80'h0);
  endtask
  // Offer one operation to the gate
  task automatic gate(input op_class_e k, input logic [SECTOR_W-1:0] s, input logic ok);
    @(negedge clock);
    op_valid = 1'b1;
    op_class = k;
    op_sector = s;
    #1;
    check(80'(op_accept), 80'(ok));
    check(80'(op_refuse), 80'(!ok));
    @(negedge clock);
    op_valid = 1'b0;
  endtask
  task automatic fclr();
    @(negedge clock);
    flag_clear = 1'b1;
    @(negedge clock);
    flag_clear = 1'b0;
    cyc(1);
  endtask
  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the expected run
  initial begin
    #2000000;
    n_mismatch++;
    test_done();
  end
  // Main sequence
  initial begin
    {clock, soft_reset, mem_rd_valid, pe_busy, erase_suspended} = '0;
    {other_suspended, op_valid, flag_clear, wcnt, lat, n_rd} = '0;
    {n_mismatch, n_compared, nxt, mem_rd_data, op_sector} = '0;
    op_class = OP_READ_MEM;
    suspended_sector = 16'h0007;
    sys_rst = 1'b1;
    fork
      h.idle(20);
      cyc(8);
    join
    sys_rst = 1'b0;
    cyc(2);
    check(80'({flag_status, crc_busy, addr4_mode, quad_mode}), 80'h0);
    read_rb(v);
    check(v, 80'h0);
    $display("test reset done");
    cmd(CMD_ADDR4_ENTER);
    check(80'(addr4_mode), 80'h1);
    cmd(CMD_ADDR4_EXIT);
    check(80'(addr4_mode), 80'h0);
    cmd(CMD_QUAD_ENTER);
    check(80'(quad_mode), 80'h1);
    h.q = 1'b1;
    cmd(CMD_QUAD_EXIT);
    h.q = 1'b0;
    check(80'(quad_mode), 80'h0);
    $display("test modes done");
    // Ranges stay inside one die
    c = ref_crc(32'h10, 32'h13);
    run_crc(~c, 32'h10, 32'h13);
    wait_done();
    check(80'(n_rd), 80'h4);
    check(80'(flag_status), 80'h10);
    read_rb(v);
    check(v, {16'h0, c});
    fclr();
    run_crc(ref_crc(32'h21, 32'h21), 32'h21, 32'h21);
    wait_done();
    check(80'(n_rd), 80'h1);
    check(80'(flag_status), 80'h0);
    read_rb(v);
    check(v, 80'h0);
    run_crc(64'h0, 32'h40, 32'h3F);
    cyc(20);
    check(80'({n_rd, flag_status}), 80'h02);
    fclr();
    $display("test crc done");
    lat = 6;
    run_crc(ref_crc(32'h0, 32'h7), 32'h0, 32'h7);
    gate(OP_SUSPEND, 16'h0000, 1'b1);
    cyc(1);
    check(80'({crc_busy, flag_status}), 80'h104);
    wait_done();
    check(80'(flag_status), 80'h0);
    run_crc(64'h0, 32'h0, 32'h7);
    soft_reset = 1'b1;
    cyc(1);
    soft_reset = 1'b0;
    cyc(2);
    check(80'({crc_busy, mem_rd_req}), 80'h0);
    read_rb(v);
    check(v, 80'h0);
    lat = 0;
    $display("test suspend and abort done");
    for (int st = 0; st < 4; st++) begin
      pe_busy = (st == 1);
      other_suspended = (st == 2);
      erase_suspended = (st == 3);
      for (int k = 0; k < 7; k++) gate(op_class_e'(k), 16'h0002, ok_in(st, op_class_e'(k)));
    end
    gate(OP_READ_MEM, 16'h0007, 1'b1);
    gate(OP_PROGRAM, 16'h0007, 1'b0);
    check(80'(flag_status[FSR_PROG]), 80'h1);
    erase_suspended = 1'b0;
    fclr();
    check(80'(flag_status), 80'h0);
    $display("test gate done");
    test_done();
  end
endmodule // flash_crc_mode_cmd_engine_tb_top
`default_nettype wire
